// File: rtl/pole_starter_pkg.sv
/*
  shared constants and carriers for the two-speed pole starter sequencer.
  assumes a 50 MHz core clock and an APB master with 32-bit data.
*/
package pole_starter_pkg;

  // ==========================================================================
  // register indices (byte address = 4 * index)
  localparam int unsigned IDX_FB_TIMER    = 26;
  localparam int unsigned IDX_F2S_WAIT    = 30;
  localparam int unsigned IDX_CONFIG      = 62;
  localparam int unsigned IDX_FCLR_FIRST  = 65;
  localparam int unsigned IDX_FCLR_LAST   = 106;
  localparam int unsigned IDX_TYPICAL     = 111;
  localparam int unsigned IDX_MAP_FIRST   = 194;
  localparam int unsigned IDX_MAP_LAST    = 197;
  localparam int unsigned IDX_CONTROL     = 200;
  localparam int unsigned IDX_STATUS      = 201;

  // ==========================================================================
  // field positions and values
  localparam int unsigned CFG_DEFAULT_BIT = 0;
  localparam int unsigned CFG_PARAM_BIT   = 1;
  localparam int unsigned CFG_TYPE_LSB    = 8;
  localparam logic [3:0]  TYPE_TWO_SPEED  = 4'h6;
  localparam int unsigned TYP_DIRECT_BIT  = 3;
  localparam int unsigned FB_LOCAL_BIT    = 9;
  localparam int unsigned FB_REMOTE_BIT   = 10;
  localparam int unsigned FB_SLOW_BIT     = 0;
  localparam int unsigned FB_FAST_BIT     = 1;
  localparam int unsigned FB_STOP_BIT     = 2;
  localparam logic [7:0]  COIL_LOCAL      = 8'h0a;
  localparam logic [7:0]  COIL_REMOTE     = 8'h0b;

  // ==========================================================================
  // reset values
  localparam logic [15:0] RST_FB_TIMER    = 16'h01f4;
  localparam logic [15:0] RST_F2S_WAIT    = 16'h03e8;
  localparam logic [15:0] RST_CONFIG      = 16'h0601;
  localparam logic [15:0] RST_TYPICAL     = 16'h0000;
  localparam logic [15:0] RST_MAP         = 16'h0000;
  localparam logic [15:0] RST_CONTROL     = 16'h0000;

  // default-mapping input inversion: star, main, estop, safety, stop active low
  localparam logic [15:0] DEFAULT_INVERT  = 16'h00dc;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned TIMER_UNIT_US   = 1000;
  localparam int unsigned UNIT_CYCLES     = CLK_HZ / 1_000_000 * TIMER_UNIT_US;
  localparam int unsigned BLINK_UNITS     = 500;

  typedef enum logic [2:0] {
    SRC_FIELDBUS     = 3'h0,
    SRC_MODBUS       = 3'h1,
    SRC_HARDWIRE     = 3'h2,
    SRC_FIXED_LOCAL  = 3'h3,
    SRC_FIXED_REMOTE = 3'h4
  } loc_src_t;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_SLOW      = 3'b001,
    ST_OPEN_LOW  = 3'b011,
    ST_STAR      = 3'b010,
    ST_HIGH      = 3'b110,
    ST_WAIT_SLOW = 3'b111
  } seq_state_t;

  // raw hardwired inputs as seen at the pins (bit order fixes the invert mask)
  typedef struct packed {
    logic [6:0] spare;
    logic       mode_remote;
    logic       stop_cmd;
    logic       safety;
    logic       ext_sup;
    logic       estop;
    logic       main_circuit;
    logic       fb_star;
    logic       fb_high;
    logic       fb_low;
  } hw_in_t;

  typedef struct packed {
    logic low_speed_contactor;
    logic high_speed_contactor;
    logic star_contactor;
  } contactor_t;

endpackage : pole_starter_pkg

// File: rtl/two_speed_pole_starter_seq.sv
/*
  two-speed pole starter sequencer with APB register access.
  assumes all pin inputs synchronous to core_clk, and an outside protection
  block that raises fault_in while any fault or device error exists.

  // Behaviour
  // RQ1: refuse starts without start permit
  // RQ2: permit off until faults are cleared
  // RQ3: permit needs a valid hardwired stop input
  // RQ4: drawer supervision input gates permit when enabled
  // RQ5: fieldbus word bit9 local, bit10 remote
  // RQ6: modbus coil 10 local, coil 11 remote
  // RQ7: hardwired local/remote select inputs
  // RQ8: fixed local accepts all local sources
  // RQ9: fixed remote accepts only remote source
  // RQ10: local plus remote request blocks permit
  // RQ11: config writes only with parameter permission
  // RQ12: slow start closes low-speed contactor
  // RQ13: fast start: open low, star, then high
  // RQ14: star waits for low feedback, timer supervised
  // RQ15: direct switchover slow to fast sequence
  // RQ16: direct switchover fast to slow waits timer
  // RQ17: config 62 bit0 and type 0x6 default
  // RQ18: default input polarities fixed per input
  // RQ19: three relays drive the three contactors
  // RQ20: permit relay over identify flash, status relays
  // RQ21: user mapping when default not selected
  // RQ22: input mapping writable at 194 to 197
  // RQ23: low never with high or star
  // RQ24: stop or permit loss opens all contactors
*/
module two_speed_pole_starter_seq #(
  parameter int unsigned UNIT_CYCLES = pole_starter_pkg::UNIT_CYCLES,
  parameter int unsigned ADDR_W      = 12
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire logic [ADDR_W-1:0]        paddr,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic [31:0]                   prdata,
  output logic                          pslverr,
  input  wire pole_starter_pkg::hw_in_t hw_in,
  input  wire logic                     drawer_sup_in,
  input  wire logic                     alarm_reset_in,
  input  wire logic                     mode_local_in,
  input  wire logic                     hw_slow_start_cmd,
  input  wire logic                     hw_fast_start_cmd,
  input  wire logic [15:0]              fieldbus_control_word,
  input  wire logic [15:0]              fieldbus_fault_clear_word,
  input  wire logic                     coil_wr_valid,
  input  wire logic [7:0]               coil_addr,
  input  wire logic                     coil_value,
  input  wire logic                     fault_in,
  output pole_starter_pkg::contactor_t  contactors,
  output logic                          permit_relay,
  output logic                          failure_relay,
  output logic                          slow_run_relay,
  output logic                          fast_run_relay,
  output logic                          local_ctrl_relay
);

  initial
  begin
    if (UNIT_CYCLES < 1 || ADDR_W < 10)
      $error("unsupported parameter values");
  end

  // ==========================================================================
  // apb decode
  logic [15:0] fb_timer_q, f2s_wait_q, config_q, typical_q, control_q;
  logic [15:0] map_q [4];
  logic        access, wr, rd;
  logic [9:0]  idx;
  logic        param_ok;

  assign access   = psel && penable;
  // addresses beyond the 10-bit index space fold onto an unmapped index
  assign idx      = (paddr >> 12) != '0 ? 10'h3ff : 10'(paddr[ADDR_W-1:2]);
  // writes land only at the completing edge, where pready is high
  assign wr       = access && pwrite && pready;
  assign rd       = access && !pwrite;
  assign param_ok = config_q[pole_starter_pkg::CFG_PARAM_BIT];

  logic idx_map, idx_fclr, idx_known;
  assign idx_map  = idx >= 10'(pole_starter_pkg::IDX_MAP_FIRST) && idx <= 10'(pole_starter_pkg::IDX_MAP_LAST);
  assign idx_fclr = idx >= 10'(pole_starter_pkg::IDX_FCLR_FIRST) && idx <= 10'(pole_starter_pkg::IDX_FCLR_LAST);
  assign idx_known = idx_map || idx_fclr ||
                     idx == 10'(pole_starter_pkg::IDX_FB_TIMER) || idx == 10'(pole_starter_pkg::IDX_F2S_WAIT) ||
                     idx == 10'(pole_starter_pkg::IDX_CONFIG) || idx == 10'(pole_starter_pkg::IDX_TYPICAL) ||
                     idx == 10'(pole_starter_pkg::IDX_CONTROL) || idx == 10'(pole_starter_pkg::IDX_STATUS);

  // ==========================================================================
  // configuration registers
  // RQ11 parameter permission gate
  logic cfg_wr;
  assign cfg_wr = wr && param_ok;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      fb_timer_q <= pole_starter_pkg::RST_FB_TIMER;
      f2s_wait_q <= pole_starter_pkg::RST_F2S_WAIT;
      typical_q  <= pole_starter_pkg::RST_TYPICAL;
      control_q  <= pole_starter_pkg::RST_CONTROL;
    end
    else if (cfg_wr)
    begin
      if (idx == 10'(pole_starter_pkg::IDX_FB_TIMER))
        fb_timer_q <= pwdata[15:0];
      if (idx == 10'(pole_starter_pkg::IDX_F2S_WAIT))
        f2s_wait_q <= pwdata[15:0];
      if (idx == 10'(pole_starter_pkg::IDX_TYPICAL))
        typical_q <= pwdata[15:0];
      if (idx == 10'(pole_starter_pkg::IDX_CONTROL))
        control_q <= pwdata[15:0];
    end
  end

  // register 62 stays writable so the permission bit can be set
  // RQ17 type and default selection
  always_ff @(posedge core_clk)
  begin
    if (rst)
      config_q <= pole_starter_pkg::RST_CONFIG;
    else if (wr && idx == 10'(pole_starter_pkg::IDX_CONFIG))
      config_q <= pwdata[15:0];
  end

  // RQ22 input mapping registers
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_map
      always_ff @(posedge core_clk)
      begin
        if (rst)
          map_q[gi] <= pole_starter_pkg::RST_MAP;
        else if (cfg_wr && idx == 10'(pole_starter_pkg::IDX_MAP_FIRST + gi))
          map_q[gi] <= pwdata[15:0];
      end
    end
  endgenerate

  // ==========================================================================
  // input polarity
  logic default_on;
  logic [15:0] invert, hw_act;
  pole_starter_pkg::hw_in_t in_act;

  assign default_on = config_q[pole_starter_pkg::CFG_DEFAULT_BIT] &&
                      config_q[pole_starter_pkg::CFG_TYPE_LSB +: 4] == pole_starter_pkg::TYPE_TWO_SPEED;
  // RQ18 default polarity mask
  // RQ21 user mask otherwise
  assign invert = default_on ? pole_starter_pkg::DEFAULT_INVERT : map_q[0];
  assign hw_act = 16'(hw_in) ^ invert;
  assign in_act = pole_starter_pkg::hw_in_t'(hw_act);

  // ==========================================================================
  // fault latch
  logic fault_q, fault_clr, seq_timeout;
  // RQ2 clear sources
  assign fault_clr = (wr && idx_fclr) || (fieldbus_fault_clear_word != 16'h0000) || alarm_reset_in;

  always_ff @(posedge core_clk)
  begin
    if (rst)
      fault_q <= 1'b0;
    else if (fault_in || seq_timeout)
      fault_q <= 1'b1;
    else if (fault_clr)
      fault_q <= 1'b0;
  end

  // ==========================================================================
  // control location
  pole_starter_pkg::loc_src_t src;
  logic coil_local_q, coil_remote_q;
  logic loc_req, rem_req;

  assign src = pole_starter_pkg::loc_src_t'(control_q[2:0]);

  // RQ6 modbus coils
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      coil_local_q  <= 1'b0;
      coil_remote_q <= 1'b0;
    end
    else if (coil_wr_valid)
    begin
      if (coil_addr == pole_starter_pkg::COIL_LOCAL)
        coil_local_q <= coil_value;
      if (coil_addr == pole_starter_pkg::COIL_REMOTE)
        coil_remote_q <= coil_value;
    end
  end

  always_comb
  begin
    loc_req = 1'b0;
    rem_req = 1'b0;
    case (src)
      // RQ5 fieldbus selection
      pole_starter_pkg::SRC_FIELDBUS:
      begin
        loc_req = fieldbus_control_word[pole_starter_pkg::FB_LOCAL_BIT];
        rem_req = fieldbus_control_word[pole_starter_pkg::FB_REMOTE_BIT];
      end
      pole_starter_pkg::SRC_MODBUS:
      begin
        loc_req = coil_local_q;
        rem_req = coil_remote_q;
      end
      // RQ7 hardwired selection
      pole_starter_pkg::SRC_HARDWIRE:
      begin
        loc_req = mode_local_in;
        rem_req = in_act.mode_remote;
      end
      // RQ8 fixed local
      pole_starter_pkg::SRC_FIXED_LOCAL: loc_req = 1'b1;
      // RQ9 fixed remote
      pole_starter_pkg::SRC_FIXED_REMOTE: rem_req = 1'b1;
      default:
      begin
        loc_req = 1'b0;
        rem_req = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // start permit
  logic permit;
  logic sup_en;
  assign sup_en = control_q[3];
  // RQ3 stop input valid
  // RQ4 drawer supervision
  // RQ10 local and remote conflict
  assign permit = !fault_q && in_act.stop_cmd && (!sup_en || drawer_sup_in) &&
                  in_act.estop && in_act.safety && (loc_req ^ rem_req);

  logic slow_cmd, fast_cmd, stop_cmd;
  always_comb
  begin
    slow_cmd = 1'b0;
    fast_cmd = 1'b0;
    stop_cmd = !in_act.stop_cmd;
    if (loc_req && !rem_req)
    begin
      slow_cmd = hw_slow_start_cmd;
      fast_cmd = hw_fast_start_cmd;
    end
    else if (rem_req && !loc_req)
    begin
      slow_cmd = fieldbus_control_word[pole_starter_pkg::FB_SLOW_BIT];
      fast_cmd = fieldbus_control_word[pole_starter_pkg::FB_FAST_BIT];
      stop_cmd = stop_cmd || fieldbus_control_word[pole_starter_pkg::FB_STOP_BIT];
    end
  end

  // ==========================================================================
  // timers in units of one millisecond
  logic [31:0] pre_q;
  logic        tick;
  logic [15:0] tmr_q;
  assign tick = pre_q == 32'(UNIT_CYCLES - 1);

  always_ff @(posedge core_clk)
  begin
    if (rst || tick)
      pre_q <= 32'h0;
    else
      pre_q <= pre_q + 32'h1;
  end

  pole_starter_pkg::seq_state_t state_q, state_d;
  logic direct_ok;
  assign direct_ok = typical_q[pole_starter_pkg::TYP_DIRECT_BIT];

  always_ff @(posedge core_clk)
  begin
    if (rst || state_d != state_q)
      tmr_q <= 16'h0;
    else if (tick && tmr_q != 16'hffff)
      tmr_q <= tmr_q + 16'h1;
  end

  // RQ14 feedback supervision timeout
  assign seq_timeout = (state_q == pole_starter_pkg::ST_OPEN_LOW || state_q == pole_starter_pkg::ST_STAR) &&
                       tmr_q >= fb_timer_q;

  // ==========================================================================
  // sequence
  always_comb
  begin
    state_d = state_q;
    // RQ24 stop or permit loss
    if (stop_cmd || !permit || seq_timeout)
      state_d = pole_starter_pkg::ST_IDLE;
    else
      unique case (state_q)
        pole_starter_pkg::ST_IDLE:
          // RQ1 starts need permit
          // RQ12 slow start
          if (fast_cmd)
            state_d = pole_starter_pkg::ST_OPEN_LOW;
          else if (slow_cmd)
            state_d = pole_starter_pkg::ST_SLOW;
        pole_starter_pkg::ST_SLOW:
          // RQ15 direct slow to fast
          if (fast_cmd && direct_ok)
            state_d = pole_starter_pkg::ST_OPEN_LOW;
        pole_starter_pkg::ST_OPEN_LOW:
          // RQ13 star after low feedback drops
          if (!in_act.fb_low)
            state_d = pole_starter_pkg::ST_STAR;
        pole_starter_pkg::ST_STAR:
          if (in_act.fb_star)
            state_d = pole_starter_pkg::ST_HIGH;
        pole_starter_pkg::ST_HIGH:
          // RQ16 direct fast to slow
          if (slow_cmd && direct_ok)
            state_d = pole_starter_pkg::ST_WAIT_SLOW;
        pole_starter_pkg::ST_WAIT_SLOW:
          if (tmr_q >= f2s_wait_q)
            state_d = pole_starter_pkg::ST_SLOW;
      endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      state_q <= pole_starter_pkg::ST_IDLE;
    else
      state_q <= state_d;
  end

  // ==========================================================================
  // relay outputs
  logic [8:0] blink_q;
  logic       blink_ph_q;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      blink_q    <= 9'h0;
      blink_ph_q <= 1'b0;
    end
    else if (tick)
    begin
      blink_q    <= blink_q == 9'(pole_starter_pkg::BLINK_UNITS - 1) ? 9'h0 : blink_q + 9'h1;
      blink_ph_q <= blink_q == 9'(pole_starter_pkg::BLINK_UNITS - 1) ? !blink_ph_q : blink_ph_q;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      contactors       <= '0;
      permit_relay     <= 1'b0;
      failure_relay    <= 1'b0;
      slow_run_relay   <= 1'b0;
      fast_run_relay   <= 1'b0;
      local_ctrl_relay <= 1'b0;
    end
    else
    begin
      // RQ19 one relay per contactor
      // RQ23 low excludes high and star
      contactors.low_speed_contactor  <= state_d == pole_starter_pkg::ST_SLOW;
      contactors.star_contactor       <= state_d == pole_starter_pkg::ST_STAR || state_d == pole_starter_pkg::ST_HIGH;
      contactors.high_speed_contactor <= state_d == pole_starter_pkg::ST_HIGH;
      // RQ20 permit over identify flash
      permit_relay     <= permit || (control_q[4] && blink_ph_q);
      failure_relay    <= fault_q;
      slow_run_relay   <= state_d == pole_starter_pkg::ST_SLOW;
      fast_run_relay   <= state_d == pole_starter_pkg::ST_HIGH;
      local_ctrl_relay <= loc_req && !rem_req;
    end
  end

  // ==========================================================================
  // apb read and answer
  logic [31:0] rdata;
  always_comb
  begin
    rdata = 32'h0;
    if (idx_map)
      rdata = {16'h0, map_q[2'(idx - 10'(pole_starter_pkg::IDX_MAP_FIRST))]};
    else if (idx == 10'(pole_starter_pkg::IDX_FB_TIMER))
      rdata = {16'h0, fb_timer_q};
    else if (idx == 10'(pole_starter_pkg::IDX_F2S_WAIT))
      rdata = {16'h0, f2s_wait_q};
    else if (idx == 10'(pole_starter_pkg::IDX_CONFIG))
      rdata = {16'h0, config_q};
    else if (idx == 10'(pole_starter_pkg::IDX_TYPICAL))
      rdata = {16'h0, typical_q};
    else if (idx == 10'(pole_starter_pkg::IDX_CONTROL))
      rdata = {16'h0, control_q};
    else if (idx == 10'(pole_starter_pkg::IDX_STATUS))
      rdata = {23'h0, rem_req, loc_req, default_on, fault_q, permit, state_q, 1'b0};
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= access && !pready;
      prdata  <= (rd && !pready) ? rdata : 32'h0;
      pslverr <= access && !pready && !idx_known;
    end
  end

  // ==========================================================================
  // checks
  property p_no_start_without_permit;
    @(posedge core_clk) disable iff (rst)
      !permit |=> !contactors.low_speed_contactor && !contactors.star_contactor;
  endproperty
  a_no_start_without_permit: assert property (p_no_start_without_permit) // RQ1
    else $error("contactor closed without permit");

  property p_fault_blocks_permit;
    @(posedge core_clk) disable iff (rst)
      fault_q && !fault_clr |=> !permit ##1 !permit_relay || control_q[4];
  endproperty
  a_fault_blocks_permit: assert property (p_fault_blocks_permit) // RQ2
    else $error("permit with pending fault");

  property p_conflict_blocks;
    @(posedge core_clk) disable iff (rst)
      loc_req && rem_req |-> !permit;
  endproperty
  a_conflict_blocks: assert property (p_conflict_blocks) // RQ10
    else $error("permit during local remote conflict");

  property p_cfg_locked;
    @(posedge core_clk) disable iff (rst)
      wr && !param_ok |=> $stable(fb_timer_q) && $stable(f2s_wait_q) && $stable(typical_q) && $stable(control_q);
  endproperty
  a_cfg_locked: assert property (p_cfg_locked) // RQ11
    else $error("config changed without permission");

  sequence s_low_released;
    !contactors.low_speed_contactor && !in_act.fb_low;
  endsequence
  property p_star_after_low;
    @(posedge core_clk) disable iff (rst)
      $rose(contactors.star_contactor) |-> $past(state_q == pole_starter_pkg::ST_OPEN_LOW) and s_low_released;
  endproperty
  a_star_after_low: assert property (p_star_after_low) // RQ14
    else $error("star closed before low feedback dropped");

  property p_high_after_star;
    @(posedge core_clk) disable iff (rst)
      $rose(contactors.high_speed_contactor) |-> $past(contactors.star_contactor) && $past(in_act.fb_star);
  endproperty
  a_high_after_star: assert property (p_high_after_star) // RQ13
    else $error("high closed without star feedback");

  property p_no_overlap;
    @(posedge core_clk) disable iff (rst)
      contactors.low_speed_contactor |-> !contactors.high_speed_contactor && !contactors.star_contactor;
  endproperty
  a_no_overlap: assert property (p_no_overlap) // RQ23
    else $error("low overlaps high or star");

  property p_stop_opens_all;
    @(posedge core_clk) disable iff (rst)
      stop_cmd |=> contactors == '0 && !slow_run_relay && !fast_run_relay;
  endproperty
  a_stop_opens_all: assert property (p_stop_opens_all) // RQ24
    else $error("contactor held after stop");

  property p_wait_before_slow;
    @(posedge core_clk) disable iff (rst)
      state_q == pole_starter_pkg::ST_WAIT_SLOW && tmr_q < f2s_wait_q |=> !contactors.low_speed_contactor;
  endproperty
  a_wait_before_slow: assert property (p_wait_before_slow) // RQ16
    else $error("low closed before wait expired");

endmodule : two_speed_pole_starter_seq

// File: dv/contactor_model.sv
/*
  contactor model: auxiliary contacts follow the coils after DLY cycles.
  assumes the contactor struct of the package and one core clock.
*/
module contactor_model #(
  parameter int DLY = 3
) (
  input  wire logic                         core_clk,
  input  wire pole_starter_pkg::contactor_t coil,
  output logic                              fb_low,
  output logic                              fb_high,
  output logic                              fb_star_n
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int T = 3 * DLY - 1;
  logic [T:0] sh_q = '0;

  // ==========================================================================
  // contact delay
  always_ff @(posedge core_clk)
  begin
    sh_q <= {sh_q[T-3:0], coil};
  end

  assign fb_low    = sh_q[T];
  assign fb_high   = sh_q[T-1];
  assign fb_star_n = ~sh_q[T-2];
endmodule : contactor_model

// File: dv/two_speed_pole_starter_seq_tb.sv
/*
  testbench for the two-speed pole starter sequencer.
  assumes the contactor model and the package; APB master of its own.
*/
module two_speed_pole_starter_seq_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                         core_clk = 1'b0, rst = 1'b1;
  logic [11:0]                  paddr = '0;
  logic                         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0]                  pwdata = '0, prdata, rd;
  logic                         pready, pslverr, err, permit_relay, failure_relay;
  logic                         slow_run_relay, fast_run_relay, local_ctrl_relay;
  logic                         drawer_sup_in = 1'b0, alarm_reset_in = 1'b0, mode_local_in = 1'b0;
  logic                         slow_cmd = 1'b0, fast_cmd = 1'b0, fault_in = 1'b0, stop_raw = 1'b0;
  logic                         coil_wr_valid = 1'b0, coil_value = 1'b0;
  logic [7:0]                   coil_addr = '0;
  logic [15:0]                  fb_word = '0, clr_word = '0;
  logic                         fb_low, fb_high, fb_star_n;
  pole_starter_pkg::contactor_t contactors;
  pole_starter_pkg::hw_in_t     hw_in;
  int                           mismatches = 0, total_checks = 0, cycles = 0, n;

  assign hw_in = {8'h00, stop_raw, 4'b0000, fb_star_n, fb_high, fb_low};

  two_speed_pole_starter_seq #(.UNIT_CYCLES(4)) u_dut (.core_clk(core_clk), .rst(rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .hw_in(hw_in), .drawer_sup_in(drawer_sup_in), .alarm_reset_in(alarm_reset_in),
    .mode_local_in(mode_local_in), .hw_slow_start_cmd(slow_cmd), .hw_fast_start_cmd(fast_cmd),
    .fieldbus_control_word(fb_word), .fieldbus_fault_clear_word(clr_word), .coil_wr_valid(coil_wr_valid),
    .coil_addr(coil_addr), .coil_value(coil_value), .fault_in(fault_in), .contactors(contactors),
    .permit_relay(permit_relay), .failure_relay(failure_relay), .slow_run_relay(slow_run_relay),
    .fast_run_relay(fast_run_relay), .local_ctrl_relay(local_ctrl_relay));

  contactor_model u_model (.core_clk(core_clk), .coil(contactors), .fb_low(fb_low), .fb_high(fb_high),
    .fb_star_n(fb_star_n));

  // ==========================================================================
  // tasks
  task report_and_stop;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task rw(input logic w, input int idx, input logic [31:0] wd);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= 12'(idx * 4);
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : rw

  task wt(input logic [2:0] v);
    n = 0;
    while (contactors !== v && n < 100)
    begin
      @(posedge core_clk);
      n++;
    end
    chk(contactors, v);
  endtask : wt

  // ==========================================================================
  // clock, timeout, sequence
  initial forever #10 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      report_and_stop;
    end
  end

  initial
  begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rw(0, 26, 0); chk(rd, 32'h01f4);
    rw(0, 62, 0); chk(rd, 32'h0601);
    rw(0, 300, 0); chk(err, 1'b1);
    rw(1, 30, 5); rw(0, 30, 0); chk(rd, 32'h03e8);
    rw(1, 62, 32'h0603);
    rw(1, 30, 5);
    rw(1, 111, 8); rw(0, 111, 0); chk(rd, 32'h0008);
    fb_word <= 16'h0600;
    slow_cmd <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk(permit_relay, 1'b0);
    chk(contactors, 3'b000);
    slow_cmd <= 1'b0;
    fb_word <= 16'h0200;
    repeat (4) @(posedge core_clk);
    chk(permit_relay, 1'b1);
    chk(local_ctrl_relay, 1'b1);
    fault_in <= 1'b1;
    @(posedge core_clk);
    fault_in <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(permit_relay, 1'b0);
    chk(failure_relay, 1'b1);
    alarm_reset_in <= 1'b1;
    @(posedge core_clk);
    alarm_reset_in <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(permit_relay, 1'b1);
    slow_cmd <= 1'b1;
    wt(3'b100);
    chk(slow_run_relay, 1'b1);
    repeat (6) @(posedge core_clk);
    slow_cmd <= 1'b0;
    fast_cmd <= 1'b1;
    wt(3'b000);
    wt(3'b001); chk(n >= 2, 1'b1);
    wt(3'b011);
    chk(fast_run_relay, 1'b1);
    fast_cmd <= 1'b0;
    slow_cmd <= 1'b1;
    wt(3'b000);
    wt(3'b100); chk(n >= 18 && n <= 30, 1'b1);
    stop_raw <= 1'b1;
    wt(3'b000);
    stop_raw <= 1'b0;
    fb_word <= 16'h0400;
    repeat (6) @(posedge core_clk);
    chk(contactors, 3'b000);
    slow_cmd <= 1'b0;
    fb_word <= 16'h0401;
    wt(3'b100);
    rw(1, 200, 1);
    coil_addr <= 8'h0b;
    coil_value <= 1'b1;
    coil_wr_valid <= 1'b1;
    @(posedge core_clk);
    coil_wr_valid <= 1'b0;
    wt(3'b000);
    wt(3'b100);
    rw(1, 200, 3);
    repeat (3) @(posedge core_clk);
    chk(local_ctrl_relay, 1'b1);
    report_and_stop;
  end
endmodule : two_speed_pole_starter_seq_tb
